//--- hdl/tx_timing_pkg.sv
// Shared constants and types for the transmit timing source select block.
`default_nettype none
package tx_timing_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SWITCH_GAP_NS = 100;
  localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CLK_SEL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;

  localparam int BIT_VIOL = 7;
  localparam int BIT_T1 = 6;
  localparam int BIT_ALIGN = 5;
  localparam int BIT_PROTECT = 4;
  localparam int BIT_STAT_LOSS = 5;

  localparam logic [7:0] CLK_SEL_RESET = 8'h11;

  typedef enum logic [1:0] {
    SRC_LINE = 2'b00,
    SRC_EXT = 2'b01,
    SRC_PLL = 2'b10,
    SRC_LINE_ALT = 2'b11
  } src_t;

  typedef struct packed {
    logic serial_clock;
    logic frame_sync;
    logic multiframe_sync;
  } pin_oe_t;

  typedef struct packed {
    logic line;
    logic ext;
    logic pll;
  } src_en_t;
endpackage : tx_timing_pkg
`default_nettype wire

//--- hdl/tx_clock_switch.sv
// Break-before-make gating of the transmit timing source enables.
`default_nettype none
module tx_clock_switch #(
  parameter int GAP_CYC = tx_timing_pkg::SWITCH_GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire tx_timing_pkg::src_t want_src,
  output tx_timing_pkg::src_en_t src_en,
  output logic settled
);
  localparam int CW = $clog2(GAP_CYC + 1);

  typedef enum logic {
    SW_RUN = 1'b0,
    SW_GAP = 1'b1
  } sw_state_t;

  typedef struct packed {
    sw_state_t st;
    tx_timing_pkg::src_t cur;
    logic [CW-1:0] cnt;
    tx_timing_pkg::src_en_t en;
  } sw_t;

  localparam sw_t SW_RESET = '{st: SW_RUN, cur: tx_timing_pkg::SRC_EXT, cnt: '0,
                               en: '{line: 1'b0, ext: 1'b1, pll: 1'b0}};

  sw_t sw_q;
  sw_t sw_d;

  function automatic tx_timing_pkg::src_en_t onehot(input tx_timing_pkg::src_t s);
    tx_timing_pkg::src_en_t e;
    e = '0;
    unique case (s)
      tx_timing_pkg::SRC_PLL: e.pll = 1'b1;
      tx_timing_pkg::SRC_EXT: e.ext = 1'b1;
      tx_timing_pkg::SRC_LINE, tx_timing_pkg::SRC_LINE_ALT: e.line = 1'b1;
    endcase
    return e;
  endfunction : onehot

  always_comb begin
    sw_d = sw_q;
    unique case (sw_q.st)
      SW_RUN: begin
        if (want_src != sw_q.cur) begin
          sw_d.st = SW_GAP;
          sw_d.cnt = CW'(GAP_CYC);
          sw_d.en = '0;
        end
      end
      SW_GAP: begin
        if (sw_q.cnt != '0) begin
          sw_d.cnt = sw_q.cnt - 1'b1;
        end else begin
          sw_d.st = SW_RUN;
          sw_d.cur = want_src;
          sw_d.en = onehot(want_src);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_q <= SW_RESET;
    end else begin
      sw_q <= sw_d;
    end
  end

  assign src_en = sw_q.en;
  assign settled = (sw_q.st == SW_RUN) && (sw_q.cur == want_src);

  // Counts the cycles during which no source is enabled.
  logic [7:0] off_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt <= 8'hff;
    end else if (sw_q.en != '0) begin
      off_cnt <= 8'h00;
    end else if (off_cnt != 8'hff) begin
      off_cnt <= off_cnt + 8'h01;
    end
  end

  property p_en_onehot0;
    @(posedge clk) disable iff (!rst_n) $onehot0(sw_q.en);
  endproperty
  a_en_onehot0: assert property (p_en_onehot0) else $error("two sources enabled");

  property p_break_before_make;
    @(posedge clk) disable iff (!rst_n)
      (sw_q.en != '0 && $changed(sw_q.en)) |-> ($past(sw_q.en) == '0 && off_cnt >= GAP_CYC);
  endproperty
  a_break_before_make: assert property (p_break_before_make) else $error("source gap short");

  c_switch_done: cover property (@(posedge clk) disable iff (!rst_n)
    sw_q.st == SW_GAP ##1 sw_q.st == SW_RUN);
endmodule : tx_clock_switch
`default_nettype wire

//--- hdl/tx_timing_source_select.sv
// Transmit timing source select with APB register access and pin direction control.
`default_nettype none
module tx_timing_source_select #(
  parameter int ADDR_W = 8,
  parameter int GAP_CYC = tx_timing_pkg::SWITCH_GAP_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LINE_CLK_LOST,
  input wire logic BASE_RATE_MODE,
  input wire logic SYNC_INVERT,
  output tx_timing_pkg::src_en_t TX_SRC_EN,
  output logic TX_SRC_SETTLED,
  output tx_timing_pkg::pin_oe_t TX_PIN_OE,
  output logic LINE_STANDARD_T1,
  output logic TX_ALIGN_ACTIVE,
  output logic LINE_CODE_VIOLATION_INSERT,
  output logic CLOCK_LOSS_STATUS
);
  typedef struct packed {
    logic [7:0] ctl;
    logic loss;
    logic viol;
    logic [2:0] sync;
    logic lost;
    logic lost_prev;
    logic align;
    tx_timing_pkg::pin_oe_t pin_oe;
    logic [31:0] prdata;
  } state_t;

  localparam state_t ST_RESET = '{ctl: tx_timing_pkg::CLK_SEL_RESET, loss: 1'b0, viol: 1'b0,
                                  sync: 3'h0, lost: 1'b0, lost_prev: 1'b0, align: 1'b0,
                                  pin_oe: '0, prdata: 32'h0000_0000};

  state_t st_q;
  state_t st_d;

  tx_timing_pkg::src_t cfg_src;
  tx_timing_pkg::src_t eff_src;
  logic line_cfg;
  logic fallback;
  logic setup;
  logic access;
  logic hit_ctl;
  logic hit_stat;
  logic wr_ctl;
  logic wr_stat;
  logic loss_set;
  logic clk_out;
  logic [31:0] status_word;

  always_comb begin
    cfg_src = tx_timing_pkg::src_t'(st_q.ctl[1:0]);
    line_cfg = (cfg_src == tx_timing_pkg::SRC_LINE) || (cfg_src == tx_timing_pkg::SRC_LINE_ALT);
    fallback = st_q.ctl[tx_timing_pkg::BIT_PROTECT] && line_cfg && st_q.lost;
    if (fallback) begin
      eff_src = tx_timing_pkg::SRC_PLL;
    end else if (line_cfg) begin
      eff_src = tx_timing_pkg::SRC_LINE;
    end else begin
      eff_src = cfg_src;
    end
  end

  always_comb begin
    setup = PSEL && !PENABLE;
    access = PSEL && PENABLE;
    hit_ctl = (PADDR == ADDR_W'(tx_timing_pkg::OFS_CLK_SEL));
    hit_stat = (PADDR == ADDR_W'(tx_timing_pkg::OFS_STATUS));
    wr_ctl = access && PWRITE && hit_ctl;
    wr_stat = access && PWRITE && hit_stat;
    status_word = {26'h0, st_q.loss, 1'b0, st_q.lost, fallback, eff_src};
    loss_set = st_q.lost && !st_q.lost_prev;
    clk_out = BASE_RATE_MODE && (cfg_src != tx_timing_pkg::SRC_EXT);
  end

  always_comb begin
    st_d = st_q;
    // A pin change is accepted once the second and third stages agree.
    st_d.sync = {st_q.sync[1:0], LINE_CLK_LOST};
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.lost = st_q.sync[2];
    end
    st_d.lost_prev = st_q.lost;
    if (wr_ctl) begin
      st_d.ctl = PWDATA[7:0];
    end
    st_d.viol = wr_ctl && PWDATA[tx_timing_pkg::BIT_VIOL] && !st_q.ctl[tx_timing_pkg::BIT_VIOL];
    if (loss_set && st_q.ctl[tx_timing_pkg::BIT_PROTECT]) begin
      st_d.loss = 1'b1;
    end else if (wr_stat && PWDATA[tx_timing_pkg::BIT_STAT_LOSS]) begin
      st_d.loss = 1'b0;
    end
    st_d.align = st_q.ctl[tx_timing_pkg::BIT_ALIGN] && (eff_src == tx_timing_pkg::SRC_PLL);
    st_d.pin_oe.serial_clock = clk_out;
    st_d.pin_oe.frame_sync = clk_out && !SYNC_INVERT;
    st_d.pin_oe.multiframe_sync = clk_out && !SYNC_INVERT;
    if (setup) begin
      if (hit_ctl) begin
        st_d.prdata = {24'h0, st_q.ctl};
      end else if (hit_stat) begin
        st_d.prdata = status_word;
      end else begin
        st_d.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  tx_clock_switch #(
    .GAP_CYC(GAP_CYC)
  ) u_switch (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .want_src(eff_src),
    .src_en(TX_SRC_EN),
    .settled(TX_SRC_SETTLED)
  );

  assign PRDATA = st_q.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !hit_ctl && !hit_stat;
  assign TX_PIN_OE = st_q.pin_oe;
  assign LINE_STANDARD_T1 = st_q.ctl[tx_timing_pkg::BIT_T1];
  assign TX_ALIGN_ACTIVE = st_q.align;
  assign LINE_CODE_VIOLATION_INSERT = st_q.viol;
  assign CLOCK_LOSS_STATUS = st_q.loss;

  // Marks the first edge after reset release.
  logic first_q;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  property p_viol_once;
    LINE_CODE_VIOLATION_INSERT |->
      $rose(st_q.ctl[tx_timing_pkg::BIT_VIOL]) ##1 !LINE_CODE_VIOLATION_INSERT;
  endproperty
  a_viol_once: assert property (p_viol_once) else $error("bad violation strobe");

  property p_viol_on_rise;
    $rose(st_q.ctl[tx_timing_pkg::BIT_VIOL]) |-> LINE_CODE_VIOLATION_INSERT;
  endproperty
  a_viol_on_rise: assert property (p_viol_on_rise) else $error("violation missed");

  property p_mode_write;
    wr_ctl |=> (LINE_STANDARD_T1 == $past(PWDATA[tx_timing_pkg::BIT_T1]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode bit not stored");

  property p_reset_val;
    first_q |-> (st_q.ctl == tx_timing_pkg::CLK_SEL_RESET && !CLOCK_LOSS_STATUS);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("wrong reset value");

  property p_align_pll;
    TX_ALIGN_ACTIVE |-> $past(st_q.ctl[tx_timing_pkg::BIT_ALIGN]) &&
                        ($past(eff_src) == tx_timing_pkg::SRC_PLL);
  endproperty
  a_align_pll: assert property (p_align_pll) else $error("align outside PLL");

  property p_fallback;
    (st_q.ctl[tx_timing_pkg::BIT_PROTECT] && line_cfg && st_q.lost) [*8] |->
      !TX_SRC_EN.line && !TX_SRC_EN.ext;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback");

  property p_loss_gated;
    $rose(CLOCK_LOSS_STATUS) |-> $past(st_q.ctl[tx_timing_pkg::BIT_PROTECT]);
  endproperty
  a_loss_gated: assert property (p_loss_gated) else $error("loss while off");

  property p_clk_dir;
    ##1 (TX_PIN_OE.serial_clock ==
         $past(BASE_RATE_MODE && st_q.ctl[1:0] != tx_timing_pkg::SRC_EXT));
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("clock pin direction");

  property p_sync_dir;
    $past(!BASE_RATE_MODE || SYNC_INVERT) |->
      !TX_PIN_OE.frame_sync && !TX_PIN_OE.multiframe_sync;
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync pin direction");

  // Count of cycles with every source gated off.
  logic [15:0] dark_q;
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dark_q <= 16'h0000;
    end else if (TX_SRC_EN != '0) begin
      dark_q <= 16'h0000;
    end else if (dark_q != 16'hffff) begin
      dark_q <= dark_q + 16'h0001;
    end
  end

  // A switch must not leave the transmitter without a clock for long.
  property p_gap_bounded;
    dark_q <= 16'(GAP_CYC + 1);
  endproperty
  a_gap_bounded: assert property (p_gap_bounded) else $error("source gap too long");

  // Once settled, the enabled gate matches the effective source.
  property p_src_line;
    (TX_SRC_SETTLED && eff_src == tx_timing_pkg::SRC_LINE) |->
      TX_SRC_EN.line && !TX_SRC_EN.ext && !TX_SRC_EN.pll;
  endproperty
  a_src_line: assert property (p_src_line) else $error("line source not enabled");

  property p_src_ext;
    (TX_SRC_SETTLED && eff_src == tx_timing_pkg::SRC_EXT) |->
      TX_SRC_EN.ext && !TX_SRC_EN.line && !TX_SRC_EN.pll;
  endproperty
  a_src_ext: assert property (p_src_ext) else $error("external source not enabled");

  property p_src_pll;
    (TX_SRC_SETTLED && eff_src == tx_timing_pkg::SRC_PLL) |->
      TX_SRC_EN.pll && !TX_SRC_EN.line && !TX_SRC_EN.ext;
  endproperty
  a_src_pll: assert property (p_src_pll) else $error("PLL source not enabled");

  property p_no_fallback_off;
    (!st_q.ctl[tx_timing_pkg::BIT_PROTECT] && line_cfg) [*8] |->
      !TX_SRC_EN.pll && !TX_SRC_EN.ext;
  endproperty
  a_no_fallback_off: assert property (p_no_fallback_off) else $error("fallback while off");

  // Register storage checks.
  property p_protect_write;
    wr_ctl |=> (st_q.ctl[tx_timing_pkg::BIT_PROTECT] == $past(PWDATA[tx_timing_pkg::BIT_PROTECT]));
  endproperty
  a_protect_write: assert property (p_protect_write) else $error("protect bit not stored");

  property p_src_field_write;
    wr_ctl |=> (st_q.ctl[1:0] == $past(PWDATA[1:0]));
  endproperty
  a_src_field_write: assert property (p_src_field_write) else $error("source not stored");

  property p_t1_hold;
    !wr_ctl |=> $stable(LINE_STANDARD_T1);
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("mode bit moved");

  property p_unmapped_keep;
    (PSEL && PENABLE && PWRITE && PSLVERR) |=> $stable(st_q.ctl);
  endproperty
  a_unmapped_keep: assert property (p_unmapped_keep) else $error("refused write stored");

  // Clock-loss status behaviour.
  property p_loss_set;
    (loss_set && st_q.ctl[tx_timing_pkg::BIT_PROTECT]) |=> CLOCK_LOSS_STATUS;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("loss not reported");

  property p_loss_hold;
    (CLOCK_LOSS_STATUS && !(wr_stat && PWDATA[tx_timing_pkg::BIT_STAT_LOSS])) |=> CLOCK_LOSS_STATUS;
  endproperty
  a_loss_hold: assert property (p_loss_hold) else $error("loss status dropped");

  property p_loss_clear;
    (wr_stat && PWDATA[tx_timing_pkg::BIT_STAT_LOSS] &&
     !(loss_set && st_q.ctl[tx_timing_pkg::BIT_PROTECT])) |=> !CLOCK_LOSS_STATUS;
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("loss status not cleared");

  // Alignment, pin direction and violation strobe width checks.
  property p_align_off;
    !$past(st_q.ctl[tx_timing_pkg::BIT_ALIGN]) |-> !TX_ALIGN_ACTIVE;
  endproperty
  a_align_off: assert property (p_align_off) else $error("align without enable");

  property p_sync_needs_clk;
    TX_PIN_OE.frame_sync |-> TX_PIN_OE.serial_clock;
  endproperty
  a_sync_needs_clk: assert property (p_sync_needs_clk) else $error("sync out, clock in");

  property p_sync_pair;
    TX_PIN_OE.frame_sync == TX_PIN_OE.multiframe_sync;
  endproperty
  a_sync_pair: assert property (p_sync_pair) else $error("sync pins disagree");

  property p_high_speed_in;
    $past(!BASE_RATE_MODE) |-> (TX_PIN_OE == '0);
  endproperty
  a_high_speed_in: assert property (p_high_speed_in) else $error("pin driven in high speed");

  property p_viol_width;
    LINE_CODE_VIOLATION_INSERT |=> !LINE_CODE_VIOLATION_INSERT;
  endproperty
  a_viol_width: assert property (p_viol_width) else $error("violation strobe too long");

  c_fallback: cover property (fallback ##[1:100] TX_SRC_EN.pll);
  c_violation: cover property (LINE_CODE_VIOLATION_INSERT);
  c_loss: cover property ($rose(CLOCK_LOSS_STATUS));
  c_align: cover property (TX_ALIGN_ACTIVE);
endmodule : tx_timing_source_select
`default_nettype wire

//--- sim/line_side_model.sv
// Far-side model: line interface loss indication and terminal serial clock source.
`default_nettype none
module line_side_model (
  input wire logic clk,
  input wire logic lose,
  input wire tx_timing_pkg::pin_oe_t pin_oe,
  output logic line_clk_lost,
  output logic ext_serial_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    line_clk_lost = 1'b0;
    ext_serial_clock = 1'b0;
  end
  // Loss indication follows the line state.
  always @(posedge clk) begin
    line_clk_lost <= lose;
  end
  // Clock supplied only while the device leaves the pin as input.
  always @(negedge clk) begin
    if (pin_oe.serial_clock === 1'b0) begin
      ext_serial_clock <= ~ext_serial_clock;
    end
  end
endmodule : line_side_model
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the transmit timing source select block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic SYS_CLK = 1'b0, RESETN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
  logic PREADY, PSLVERR, rerr, LINE_CLK_LOST, BASE_RATE_MODE = 1'b1, SYNC_INVERT = 1'b0;
  logic lose = 1'b0, LINE_STANDARD_T1, TX_ALIGN_ACTIVE, TX_SRC_SETTLED, viol, loss_stat;
  tx_timing_pkg::src_en_t TX_SRC_EN;
  tx_timing_pkg::pin_oe_t TX_PIN_OE;
  int n_mismatch = 0, checks = 0, pulses = 0, p0;
  always #2.5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) if (viol === 1'b1) pulses++;
  line_side_model LSM (.clk(SYS_CLK), .lose(lose), .pin_oe(TX_PIN_OE),
    .line_clk_lost(LINE_CLK_LOST), .ext_serial_clock());
  tx_timing_source_select #(.GAP_CYC(2)) DUT (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINE_CLK_LOST(LINE_CLK_LOST),
    .BASE_RATE_MODE(BASE_RATE_MODE), .SYNC_INVERT(SYNC_INVERT), .TX_SRC_EN(TX_SRC_EN),
    .TX_SRC_SETTLED(TX_SRC_SETTLED), .TX_PIN_OE(TX_PIN_OE), .LINE_STANDARD_T1(LINE_STANDARD_T1),
    .TX_ALIGN_ACTIVE(TX_ALIGN_ACTIVE), .LINE_CODE_VIOLATION_INSERT(viol),
    .CLOCK_LOSS_STATUS(loss_stat));
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk("read data", exp, rdat & m);
  endtask : rd
  task wait_en(input logic [2:0] exp);
    int n;
    n = 0;
    repeat (3) @(posedge SYS_CLK);
    while (TX_SRC_EN !== exp && n < 100) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("source enable", {29'h0, exp}, {29'h0, TX_SRC_EN});
    chk("settled", 32'h1, {31'h0, TX_SRC_SETTLED});
  endtask : wait_en
  task stop_test;
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    rd(8'h00, 32'h11, 32'hffffffff);
    chk("reset enable", 32'h2, {29'h0, TX_SRC_EN});
    chk("reset pin oe", 32'h0, {29'h0, TX_PIN_OE});
    apb(1'b1, 8'h08, 32'hff);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'h00, 32'h10 | s);
      repeat (2) @(posedge SYS_CLK);
      chk("switch gap", 32'h0, {29'h0, TX_SRC_EN});
      wait_en(s == 1 ? 3'b010 : s == 2 ? 3'b001 : 3'b100);
      chk("pin oe", s == 1 ? 32'h0 : 32'h7, {29'h0, TX_PIN_OE});
    end
    apb(1'b1, 8'h00, 32'h32);
    wait_en(3'b001);
    chk("align on", 32'h1, {31'h0, TX_ALIGN_ACTIVE});
    SYNC_INVERT <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    chk("sync invert oe", 32'h4, {29'h0, TX_PIN_OE});
    BASE_RATE_MODE <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    chk("high speed oe", 32'h0, {29'h0, TX_PIN_OE});
    BASE_RATE_MODE <= 1'b1;
    SYNC_INVERT <= 1'b0;
    apb(1'b1, 8'h00, 32'h70);
    wait_en(3'b100);
    chk("align off", 32'h0, {31'h0, TX_ALIGN_ACTIVE});
    chk("t1 mode", 32'h1, {31'h0, LINE_STANDARD_T1});
    p0 = pulses;
    apb(1'b1, 8'h00, 32'hb0);
    apb(1'b1, 8'h00, 32'hb0);
    repeat (4) @(posedge SYS_CLK);
    chk("violation count", 32'h1, pulses - p0);
    chk("e1 mode", 32'h0, {31'h0, LINE_STANDARD_T1});
    lose <= 1'b1;
    wait_en(3'b001);
    rd(8'h04, 32'h20, 32'h20);
    lose <= 1'b0;
    wait_en(3'b100);
    apb(1'b1, 8'h04, 32'h20);
    rd(8'h04, 32'h0, 32'h20);
    apb(1'b1, 8'h00, 32'h00);
    lose <= 1'b1;
    repeat (30) @(posedge SYS_CLK);
    chk("no fallback", 32'h4, {29'h0, TX_SRC_EN});
    rd(8'h04, 32'h0, 32'h20);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
